// File: design/dci_channel_flags.sv
// channel status, trigger select and interrupt flags behind an axi4-lite slave
module dci_channel_flags #(
   parameter int          ADDR_W  = 8,
   parameter logic [15:0] RAM_TOP = 16'h27ff
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // channel datapath
   input  wire logic              channel_enable,
   input  wire logic              session_start,
   input  wire logic [15:0]       start_count,
   input  wire logic [15:0]       remaining_transfer_count,
   input  wire logic              session_done,
   input  wire logic              trigger,
   input  wire logic              channel_busy,
   input  wire logic              access_valid,
   input  wire logic              access_sfr,
   input  wire logic [15:0]       access_addr,
   input  wire logic [15:0]       upper_address_limit,
   input  wire logic [15:0]       lower_address_limit,
   input  wire logic              nullw_buf_load,
   input  wire logic              nullw_buf_written,
   // control out
   output      logic [5:0]        trigger_source_select,
   output      logic              midpoint_interrupt_enable,
   output      logic              buffered_write_pending_flag,
   output      logic              irq
);
   // ****************
   // elaboration checks
   // ****************
   generate
      if (ADDR_W < 4) begin : g_bad_aw
         $error("address width too small for register map");
      end
   endgenerate

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = ({{(ADDR_W-2){1'b0}}, a[1:0]} == '0) &&
            (ADDR_W'(off) == a);
   endfunction : hit

   // ****************
   // state
   // ****************
   logic [15:0]       chan;
   logic [4:0]        istat;
   logic [4:0]        imask;
   logic              bufw;
   logic [15:0]       half_pt;
   logic              half_arm;
   logic              aw_hold;
   logic              w_hold;
   logic [ADDR_W-1:0] aw_q;
   logic [31:0]       w_q;
   logic [3:0]        ws_q;

   // ****************
   // hardware events
   // ****************
   wire ev_high = access_valid && ((access_addr > upper_address_limit) ||
                  (access_addr > RAM_TOP));
   wire ev_low  = access_valid && access_sfr &&
                  (access_addr < lower_address_limit) &&
                  (access_addr > dci_pkg::SFR_TOP);
   wire ev_ovr  = trigger && channel_busy;
   wire ev_half = half_arm && !session_start &&
                  (remaining_transfer_count == half_pt);
   wire ev_done = session_done;
   wire [4:0] ev = {ev_low, ev_high, ev_ovr,
                    ev_half && chan[dci_pkg::BIT_MIDPOINT_INTERRUPT_ENABLE],
                    ev_done};
   wire [15:0] ev_flags = {8'h00, ev_high, ev_low, ev_done, ev_half,
                           ev_ovr, 3'h0};

   // ****************
   // bus decode
   // ****************
   wire do_wr    = aw_hold && w_hold && !s_axi_bvalid;
   wire do_rd    = s_axi_arvalid && s_axi_arready;
   wire wr_chan  = do_wr && hit(aw_q, dci_pkg::OFF_CHAN);
   wire wr_imask = do_wr && hit(aw_q, dci_pkg::OFF_IMASK);
   wire wr_ok    = wr_chan || wr_imask || hit(aw_q, dci_pkg::OFF_ISTAT);
   wire rd_chan  = hit(s_axi_araddr, dci_pkg::OFF_CHAN);
   wire rd_istat = hit(s_axi_araddr, dci_pkg::OFF_ISTAT);
   wire rd_imask = hit(s_axi_araddr, dci_pkg::OFF_IMASK);
   wire [15:0] lane_m = {{8{ws_q[1]}}, {8{ws_q[0]}}};
   wire [15:0] wm = dci_pkg::CHAN_WMASK & lane_m;
   wire [15:0] chan_rd = chan |
               (16'(bufw) << dci_pkg::BIT_BUFW);
   wire [31:0] rd_mux = rd_chan  ? {16'h0000, chan_rd} :
                        rd_istat ? {27'h0, istat} :
                        rd_imask ? {27'h0, imask} : 32'h0;
   wire rd_ok = rd_chan || rd_istat || rd_imask;

   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // ****************
   // channel register next value
   // ****************
   logic [15:0] next_chan;
   always_comb begin
      next_chan = chan;
      if (wr_chan) begin
         next_chan = (chan & ~wm) | (w_q[15:0] & wm);
      end
      if (session_start) begin
         next_chan[dci_pkg::BIT_DONE] = 1'b0;
      end
      next_chan = next_chan | ev_flags;
   end

   wire [4:0] next_istat = (do_rd && rd_istat ? 5'h00 : istat) | ev;

   // ****************
   // registers
   // ****************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chan  <= dci_pkg::CHAN_RST;
         istat <= dci_pkg::EV_RST;
         imask <= dci_pkg::EV_RST;
      end else begin
         chan  <= next_chan;
         istat <= next_istat;
         if (wr_imask && ws_q[0]) begin
            imask <= w_q[4:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bufw <= 1'b0;
      end else if (nullw_buf_load) begin
         bufw <= 1'b1;
      end else if (nullw_buf_written) begin
         bufw <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         half_pt  <= 16'h0000;
         half_arm <= 1'b0;
      end else if (session_start) begin
         half_pt  <= start_count >> 1;
         half_arm <= 1'b1;
      end else if (ev_half || session_done) begin
         half_arm <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_q    <= '0;
         w_q     <= 32'h0;
         ws_q    <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_q    <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_hold <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_q    <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
         end else if (do_wr) begin
            w_hold <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= dci_pkg::RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? dci_pkg::RESP_OKAY : dci_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= dci_pkg::RESP_OKAY;
      end else if (do_rd) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_ok ? dci_pkg::RESP_OKAY : dci_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************
   // outputs
   // ****************
   assign trigger_source_select =
          chan[dci_pkg::SEL_LO +: dci_pkg::SEL_W];
   assign midpoint_interrupt_enable   = chan[dci_pkg::BIT_MIDPOINT_INTERRUPT_ENABLE];
   assign buffered_write_pending_flag = bufw;
   assign irq = |(istat & imask);

   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_bufw_set: assert property (nullw_buf_load |=> bufw)
      else $error("buffered-write flag not set");
   a_bufw_clr: assert property
      (nullw_buf_written && !nullw_buf_load |=> !bufw ##0 !chan_rd[15])
      else $error("buffered-write flag not cleared");
   a_sel_write: assert property
      (wr_chan && ws_q[1] |=> trigger_source_select == $past(w_q[13:8]))
      else $error("trigger select not written");
   a_high_flag: assert property
      (access_valid && access_addr > upper_address_limit |=> chan[dci_pkg::BIT_HIGH]
       ##0 istat[dci_pkg::EV_HIGH])
      else $error("high limit flag missing");
   a_low_flag: assert property
      (ev_low |=> chan[dci_pkg::BIT_LOW] ##0 istat[dci_pkg::EV_LOW])
      else $error("low limit flag missing");
   a_done_start: assert property
      (session_start && !session_done |=> !chan[dci_pkg::BIT_DONE])
      else $error("done not cleared at session start");
   a_done_set: assert property
      (session_done |=> chan[dci_pkg::BIT_DONE] ##0 istat[dci_pkg::EV_DONE])
      else $error("done flag not set");
   a_half_flag: assert property
      (ev_half |=> chan[dci_pkg::BIT_HALF])
      else $error("half flag not set");
   a_ovr_flag: assert property
      (trigger && channel_busy |=> chan[dci_pkg::BIT_OVR] ##0 istat[dci_pkg::EV_OVR])
      else $error("overrun flag not set");
   a_half_gate: assert property
      ($rose(istat[dci_pkg::EV_HALF]) |-> $past(chan[dci_pkg::BIT_MIDPOINT_INTERRUPT_ENABLE]))
      else $error("half interrupt without enable");
   a_sw_no_irq: assert property
      (|(istat & ~$past(istat)) |-> |$past(ev))
      else $error("status bit rose without event");
   a_rsvd_zero: assert property
      (s_axi_rvalid && $past(rd_chan && do_rd) |-> s_axi_rdata[14] == 1'b0
       && s_axi_rdata[2:1] == 2'h0)
      else $error("unimplemented bits read non-zero");
   a_flag_hold: assert property
      (chan[dci_pkg::BIT_OVR] && !wr_chan |=> chan[dci_pkg::BIT_OVR])
      else $error("overrun flag lost without write");

   c_half_irq: cover property (ev_half && chan[dci_pkg::BIT_MIDPOINT_INTERRUPT_ENABLE] ##1 irq);
   c_overrun:  cover property (trigger && channel_busy);
   c_rd_clear: cover property (do_rd && rd_istat && |istat);
   c_wr_set:   cover property (wr_chan && |(w_q[7:3]) && !(|ev));
   c_dis_done: cover property (!channel_enable && chan[dci_pkg::BIT_DONE]);
endmodule : dci_channel_flags

// File: include/dci_pkg.sv
// package: register map, field layout and constants of the channel flag block
package dci_pkg;
   // ****************
   // register offsets
   // ****************
   localparam logic [7:0]  OFF_CHAN    = 8'h00;
   localparam logic [7:0]  OFF_ISTAT   = 8'h04;
   localparam logic [7:0]  OFF_IMASK   = 8'h08;
   // ****************
   // channel register fields
   // ****************
   localparam int          BIT_BUFW    = 15;
   localparam int          SEL_LO      = 8;
   localparam int          SEL_W       = 6;
   localparam int          BIT_HIGH    = 7;
   localparam int          BIT_LOW     = 6;
   localparam int          BIT_DONE    = 5;
   localparam int          BIT_HALF    = 4;
   localparam int          BIT_OVR     = 3;
   localparam int          BIT_MIDPOINT_INTERRUPT_ENABLE  = 0;
   localparam logic [15:0] CHAN_WMASK  = 16'h3ff9;
   localparam logic [15:0] CHAN_RST    = 16'h0000;
   // ****************
   // interrupt status layout
   // ****************
   localparam int          EV_DONE     = 0;
   localparam int          EV_HALF     = 1;
   localparam int          EV_OVR      = 2;
   localparam int          EV_HIGH     = 3;
   localparam int          EV_LOW      = 4;
   localparam int          EV_N        = 5;
   localparam logic [4:0]  EV_RST      = 5'h00;
   // ****************
   // address space and bus answers
   // ****************
   localparam logic [15:0] SFR_TOP     = 16'h07ff;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : dci_pkg

// File: test/dci_dp_model.sv
// channel datapath model driving the event inputs of the flag block
module dci_dp_model (
   // clock
   input  wire logic        core_clk,
   // datapath drive
   output      logic        channel_enable,
   output      logic        session_start,
   output      logic [15:0] start_count,
   output      logic [15:0] remaining_transfer_count,
   output      logic        session_done,
   output      logic        trigger,
   output      logic        channel_busy,
   output      logic        access_valid,
   output      logic        access_sfr,
   output      logic [15:0] access_addr,
   output      logic [15:0] upper_address_limit,
   output      logic [15:0] lower_address_limit,
   output      logic        nullw_buf_load,
   output      logic        nullw_buf_written
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {channel_enable, session_start, start_count, remaining_transfer_count, session_done} = '0;
      {trigger, channel_busy, access_valid, access_sfr, access_addr} = '0;
      {upper_address_limit, lower_address_limit, nullw_buf_load, nullw_buf_written} = '0;
   end
   // ****************
   // session control
   // ****************
   task start(input logic [15:0] n);
      @(posedge core_clk);
      channel_enable <= 1'b1;
      session_start <= 1'b1;
      start_count <= n;
      remaining_transfer_count <= n;
      @(posedge core_clk);
      session_start <= 1'b0;
   endtask : start
   task cnt(input int k);
      repeat (k) begin
         @(posedge core_clk);
         remaining_transfer_count <= remaining_transfer_count - 16'h1;
      end
   endtask : cnt
   task en(input logic e);
      @(posedge core_clk);
      channel_enable <= e;
   endtask : en
   // ****************
   // one-cycle events: done, trigger, buffer load, buffer written
   // ****************
   task ev(input logic [3:0] k, input logic busy);
      @(posedge core_clk);
      {session_done, trigger, nullw_buf_load, nullw_buf_written} <= k;
      channel_busy <= busy;
      @(posedge core_clk);
      {session_done, trigger, nullw_buf_load, nullw_buf_written} <= 4'h0;
      channel_busy <= 1'b0;
   endtask : ev
   // ****************
   // bus accesses: the address is shown only while the access takes place
   // ****************
   task acc(input logic [15:0] a, input logic s);
      @(posedge core_clk);
      access_valid <= 1'b1;
      access_addr <= a;
      access_sfr <= s;
      @(posedge core_clk);
      access_valid <= 1'b0;
      access_addr <= ~a;
      access_sfr <= ~s;
   endtask : acc
   task lim(input logic [15:0] u, input logic [15:0] l);
      @(posedge core_clk);
      upper_address_limit <= u;
      lower_address_limit <= l;
   endtask : lim
endmodule : dci_dp_model

// File: test/tb_top.sv
// self-checking bench of the channel flag block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic [7:0]  awaddr   = 8'h00;
   logic [7:0]  araddr   = 8'h00;
   logic [31:0] wdata    = 32'h0;
   logic [3:0]  wstrb    = 4'hf;
   logic        awvalid  = 1'b0;
   logic        wvalid   = 1'b0;
   logic        bready   = 1'b0;
   logic        arvalid  = 1'b0;
   logic        rready   = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, midp_en, bufw, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [5:0]  tsel;
   logic        c_en, s_st, s_dn, trg, busy, a_v, a_s, b_ld, b_wr;
   logic [15:0] s_cnt, r_cnt, a_ad, u_lim, l_lim;
   int          errors = 0;
   int          check_count = 0;
   int          cycles = 0;
   always #4 core_clk = ~core_clk;
   dci_channel_flags uut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .channel_enable(c_en),
      .session_start(s_st), .start_count(s_cnt), .remaining_transfer_count(r_cnt), .session_done(s_dn),
      .trigger(trg), .channel_busy(busy), .access_valid(a_v), .access_sfr(a_s), .access_addr(a_ad),
      .upper_address_limit(u_lim), .lower_address_limit(l_lim), .nullw_buf_load(b_ld),
      .nullw_buf_written(b_wr), .trigger_source_select(tsel), .midpoint_interrupt_enable(midp_en),
      .buffered_write_pending_flag(bufw), .irq(irq));
   dci_dp_model dp (.core_clk(core_clk), .channel_enable(c_en), .session_start(s_st), .start_count(s_cnt),
      .remaining_transfer_count(r_cnt), .session_done(s_dn), .trigger(trg), .channel_busy(busy),
      .access_valid(a_v), .access_sfr(a_s), .access_addr(a_ad), .upper_address_limit(u_lim),
      .lower_address_limit(l_lim), .nullw_buf_load(b_ld), .nullw_buf_written(b_wr));
   // ****************
   // compare, verdict and hang limit
   // ****************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         stop_test();
      end
   end
   // ****************
   // axi4-lite master
   // ****************
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic b;
      b = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            b = 1'b1;
            bready <= 1'b0;
            chk("bresp", {30'h0, bresp}, {30'h0, er});
         end
      end
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic b;
      b = 1'b0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!b) begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            b = 1'b1;
            rready <= 1'b0;
            chk("rresp", {30'h0, rresp}, {30'h0, er});
            chk("rdata", rdata, e);
         end
      end
   endtask : rd
   // ****************
   // test sequence
   // ****************
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_IMASK, 32'h1f, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_CHAN, 32'hffffffff, dci_pkg::RESP_OKAY);
      rd(dci_pkg::OFF_CHAN, 32'h3ff9, dci_pkg::RESP_OKAY);
      chk("tsel", {26'h0, tsel}, 32'h3f);
      chk("irq", {31'h0, irq}, 32'h0);
      rd(dci_pkg::OFF_ISTAT, 32'h0, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_CHAN, 32'h2a01, dci_pkg::RESP_OKAY);
      rd(dci_pkg::OFF_CHAN, 32'h2a01, dci_pkg::RESP_OKAY);
      chk("midp_en", {31'h0, midp_en}, 32'h1);
      wstrb <= 4'h2;
      wr(dci_pkg::OFF_CHAN, 32'h00002a00, dci_pkg::RESP_OKAY);
      wstrb <= 4'h1;
      wr(dci_pkg::OFF_CHAN, 32'h00001501, dci_pkg::RESP_OKAY);
      wstrb <= 4'hf;
      rd(dci_pkg::OFF_CHAN, 32'h2a01, dci_pkg::RESP_OKAY);
      dp.start(16'h0008);
      dp.cnt(4);
      rd(dci_pkg::OFF_CHAN, 32'h2a11, dci_pkg::RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(dci_pkg::OFF_ISTAT, 32'h02, dci_pkg::RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h0);
      dp.ev(4'h8, 1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h2a31, dci_pkg::RESP_OKAY);
      rd(dci_pkg::OFF_ISTAT, 32'h01, dci_pkg::RESP_OKAY);
      dp.start(16'h0008);
      rd(dci_pkg::OFF_CHAN, 32'h2a11, dci_pkg::RESP_OKAY);
      dp.en(1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h2a11, dci_pkg::RESP_OKAY);
      dp.ev(4'h8, 1'b0);
      dp.en(1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h2a31, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      rd(dci_pkg::OFF_ISTAT, 32'h01, dci_pkg::RESP_OKAY);
      dp.start(16'h0008);
      dp.cnt(4);
      rd(dci_pkg::OFF_ISTAT, 32'h0, dci_pkg::RESP_OKAY);
      dp.ev(4'h4, 1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h0010, dci_pkg::RESP_OKAY);
      dp.ev(4'h4, 1'b1);
      rd(dci_pkg::OFF_CHAN, 32'h0018, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      rd(dci_pkg::OFF_ISTAT, 32'h04, dci_pkg::RESP_OKAY);
      dp.lim(16'hffff, 16'h1000);
      dp.acc(16'h0700, 1'b1);
      dp.acc(16'h1000, 1'b1);
      rd(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      dp.acc(16'h0fff, 1'b1);
      rd(dci_pkg::OFF_CHAN, 32'h0040, dci_pkg::RESP_OKAY);
      dp.acc(16'h2800, 1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h00c0, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_IMASK, 32'h0, dci_pkg::RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(dci_pkg::OFF_IMASK, 32'h1f, dci_pkg::RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(dci_pkg::OFF_ISTAT, 32'h18, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      dp.lim(16'h1fff, 16'h1000);
      rd(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      dp.acc(16'h2000, 1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h0080, dci_pkg::RESP_OKAY);
      wr(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      dp.ev(4'h2, 1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h8000, dci_pkg::RESP_OKAY);
      chk("bufw", {31'h0, bufw}, 32'h1);
      dp.ev(4'h1, 1'b0);
      rd(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      rd(8'h0c, 32'h0, dci_pkg::RESP_SLVERR);
      wr(8'h0c, 32'hffff, dci_pkg::RESP_SLVERR);
      wr(dci_pkg::OFF_CHAN, 32'h3f01, dci_pkg::RESP_OKAY);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(dci_pkg::OFF_CHAN, 32'h0, dci_pkg::RESP_OKAY);
      chk("midp_en", {31'h0, midp_en}, 32'h0);
      stop_test();
   end
endmodule : tb_top
